/* hw/servo_brake_status_sequencer.sv */
// Local design decisions: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
// Summary of operation
// - Rotation flag high while speed magnitude exceeds rotation threshold.
// - Alarm latches while deviation magnitude exceeds overflow limit.
// - Brake timing settings act only when brake function is enabled.
// - Positive on-wait: brake output first, wait, then excite motor.
// - Negative on-wait: excite first, brake output after the magnitude.
// - Motor stopped at servo off: brake output drops at once.
// - Excitation removed after off-wait times ten milliseconds.
// - After off, brake output rises when speed drops below threshold.
// - After off, brake output rises when elapsed exceeds wait times ten ms.
// - Whichever of speed or time condition comes first sets brake.
module servo_brake_status_sequencer #(
  parameter int TICK_CYCLES = servo_brake_pkg::TICK_CYCLES
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic SERVO_ON_CMD,
  input wire logic [servo_brake_pkg::SPEED_W-1:0] MOTOR_SPEED,
  input wire logic [servo_brake_pkg::DEV_W-1:0] DEVIATION_COUNT,
  output logic ROTATION_DETECTED,
  output logic DEVIATION_ALARM,
  output logic HOLDING_BRAKE_OUTPUT,
  output logic MOTOR_EXCITE
);
  import servo_brake_pkg::*;

  // Magnitude of a two's complement word
  function automatic logic [31:0] mag32(input logic [31:0] v);
    mag32 = v[31] ? 32'(-v) : v;
  endfunction

  // Unsigned clamp into a range
  function automatic logic [31:0] clamp_u(input logic [31:0] v,
                                         input int lo, input int hi);
    if (v < 32'(lo)) begin
      clamp_u = 32'(lo);
    end else if (v > 32'(hi)) begin
      clamp_u = 32'(hi);
    end else begin
      clamp_u = v;
    end
  endfunction

  // Signed clamp into a symmetric range
  function automatic logic [31:0] clamp_s(input logic [31:0] v,
                                         input int lim);
    if ($signed(v) > lim) begin
      clamp_s = 32'(lim);
    end else if ($signed(v) < -lim) begin
      clamp_s = 32'(-lim);
    end else begin
      clamp_s = v;
    end
  endfunction

  // Settings
  logic brake_en;
  logic [ROT_W-1:0] rot_thr;
  logic [OVF_W-1:0] ovf_lim;
  logic [SON_W-1:0] son_wait;
  logic [SOFF_W-1:0] soff_wait;
  logic [BSPD_W-1:0] bspd_thr;
  logic [BWAIT_W-1:0] bwait;

  // Bus data phase tracking
  logic wr_pend;
  logic [7:0] addr_q;

  // Sequencer state
  seq_state_e state;
  seq_state_e next_state;
  logic next_brake;
  logic next_excite;
  logic pending;
  logic next_pending;
  logic cmd_q;
  logic next_alarm;
  logic tick;
  logic [ELAPSED_W-1:0] elapsed;

  // Address phase decode
  wire take = HSEL && HREADY && HTRANS[1];
  wire word_ok = (HSIZE == HSIZE_WORD) && (HADDR[31:8] == 24'h00_0000);
  wire take_wr = take && HWRITE && word_ok;
  wire take_rd = take && !HWRITE;
  wire [7:0] rd_ofs = HADDR[7:0];
  wire rd_hi_ok = (HADDR[31:8] == 24'h00_0000);

  // Data phase write strobes
  wire wr_ctrl = wr_pend && (addr_q == OFS_CTRL);
  wire wr_rot = wr_pend && (addr_q == OFS_ROT);
  wire wr_ovf = wr_pend && (addr_q == OFS_OVF);
  wire wr_son = wr_pend && (addr_q == OFS_SON);
  wire wr_soff = wr_pend && (addr_q == OFS_SOFF);
  wire wr_bspd = wr_pend && (addr_q == OFS_BSPD);
  wire wr_bwait = wr_pend && (addr_q == OFS_BWAIT);
  wire wr_stat = wr_pend && (addr_q == OFS_STATUS);

  // Measured magnitudes
  wire [31:0] speed_mag = mag32(32'($signed(MOTOR_SPEED)));
  wire [31:0] dev_mag = mag32(DEVIATION_COUNT);
  wire rot_now = speed_mag > 32'(rot_thr);
  wire dev_over = dev_mag > 32'(ovf_lim);

  // Alarm: a new overflow wins over a software clear
  wire alarm_clr = wr_stat && HWDATA[STAT_ALARM_BIT];
  assign next_alarm = dev_over || (DEVIATION_ALARM && !alarm_clr);

  // Command edges restart the timing
  wire on_edge = SERVO_ON_CMD && !cmd_q;
  wire off_edge = !SERVO_ON_CMD && cmd_q;
  wire restart = on_edge || off_edge;

  // Wait targets in milliseconds
  wire son_neg = son_wait[SON_W-1];
  wire son_zero = (son_wait == '0);
  wire [SON_W-1:0] son_abs = son_neg ? SON_W'(-son_wait) : son_wait;
  wire [ELAPSED_W-1:0] son_ms = ELAPSED_W'(son_abs);
  wire [ELAPSED_W-1:0] soff_ms = ELAPSED_W'(soff_wait * WAIT_UNIT_MS);
  wire [ELAPSED_W-1:0] bwait_ms = ELAPSED_W'(bwait * WAIT_UNIT_MS);

  // Timing and speed conditions
  wire on_wait_done = elapsed >= son_ms;
  wire off_wait_done = elapsed >= soff_ms;
  wire brake_time_met = elapsed > bwait_ms;
  wire brake_speed_met = speed_mag < 32'(bspd_thr);
  wire stopped = !ROTATION_DETECTED;

  // Register read selection
  wire [31:0] status_word = {26'h000_0000, 2'(state), MOTOR_EXCITE,
                             HOLDING_BRAKE_OUTPUT, DEVIATION_ALARM,
                             ROTATION_DETECTED};
  wire [31:0] rd_word =
    !rd_hi_ok ? ZERO_WORD :
    (rd_ofs == OFS_CTRL) ? 32'(brake_en) :
    (rd_ofs == OFS_ROT) ? 32'(rot_thr) :
    (rd_ofs == OFS_OVF) ? 32'(ovf_lim) :
    (rd_ofs == OFS_SON) ? 32'($signed(son_wait)) :
    (rd_ofs == OFS_SOFF) ? 32'(soff_wait) :
    (rd_ofs == OFS_BSPD) ? 32'(bspd_thr) :
    (rd_ofs == OFS_BWAIT) ? 32'(bwait) :
    (rd_ofs == OFS_STATUS) ? status_word :
    (rd_ofs == OFS_ELAPSED) ? 32'(elapsed) : ZERO_WORD;

  // Millisecond tick and elapsed time since last command
  ms_prescaler #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk(CLK),
    .rst_n(RST_N),
    .ce(CE),
    .restart(restart),
    .tick(tick)
  );

  delay_timer #(
    .W(ELAPSED_W)
  ) u_timer (
    .clk(CLK),
    .rst_n(RST_N),
    .ce(CE),
    .restart(restart),
    .tick(tick),
    .elapsed(elapsed)
  );

  // AHB-Lite slave, zero wait states, always OKAY
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      wr_pend <= 1'b0;
      addr_q <= 8'h00;
      HRDATA <= ZERO_WORD;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else if (CE) begin
      wr_pend <= take_wr;
      addr_q <= HADDR[7:0];
      HRDATA <= take_rd ? rd_word : ZERO_WORD;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
  end

  // Setting registers, values clamped to their legal ranges
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      brake_en <= CTRL_RST;
      rot_thr <= ROT_RST;
      ovf_lim <= OVF_RST;
      son_wait <= SON_RST;
      soff_wait <= SOFF_RST;
      bspd_thr <= BSPD_RST;
      bwait <= BWAIT_RST;
    end else if (CE) begin
      if (wr_ctrl) begin
        brake_en <= HWDATA[CTRL_BRAKE_EN_BIT];
      end
      if (wr_rot) begin
        rot_thr <= ROT_W'(clamp_u(HWDATA, 0, ROT_MAX));
      end
      if (wr_ovf) begin
        ovf_lim <= OVF_W'(clamp_u(HWDATA, OVF_MIN, OVF_MAX));
      end
      if (wr_son) begin
        son_wait <= SON_W'(clamp_s(HWDATA, SON_LIM));
      end
      if (wr_soff) begin
        soff_wait <= SOFF_W'(clamp_u(HWDATA, 0, SOFF_MAX));
      end
      if (wr_bspd) begin
        bspd_thr <= BSPD_W'(clamp_u(HWDATA, BSPD_MIN, BSPD_MAX));
      end
      if (wr_bwait) begin
        bwait <= BWAIT_W'(clamp_u(HWDATA, BWAIT_MIN, BWAIT_MAX));
      end
    end
  end

  // Status outputs
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ROTATION_DETECTED <= 1'b0;
      DEVIATION_ALARM <= 1'b0;
      cmd_q <= 1'b0;
    end else if (CE) begin
      ROTATION_DETECTED <= rot_now;
      DEVIATION_ALARM <= next_alarm;
      cmd_q <= SERVO_ON_CMD;
    end
  end

  // Brake and excitation sequencing
  always_comb begin
    next_state = state;
    next_brake = HOLDING_BRAKE_OUTPUT;
    next_excite = MOTOR_EXCITE;
    next_pending = pending;
    if (on_edge) begin
      next_pending = 1'b0;
      if (!brake_en || son_zero) begin
        next_state = ST_RUN;
        next_excite = 1'b1;
        next_brake = brake_en;
      end else if (son_neg) begin
        next_state = ST_ON_WAIT;
        next_excite = 1'b1;
        next_brake = 1'b0;
      end else begin
        next_state = ST_ON_WAIT;
        next_excite = 1'b0;
        next_brake = 1'b1;
      end
    end else if (off_edge) begin
      if (!brake_en) begin
        next_state = ST_IDLE;
        next_excite = 1'b0;
        next_brake = 1'b0;
        next_pending = 1'b0;
      end else begin
        next_state = ST_OFF_WAIT;
        next_excite = MOTOR_EXCITE && (soff_wait != '0);
        next_brake = stopped ? 1'b0 : HOLDING_BRAKE_OUTPUT;
        next_pending = !stopped;
      end
    end else begin
      case (state)
        ST_ON_WAIT: begin
          if (on_wait_done) begin
            next_state = ST_RUN;
            next_excite = 1'b1;
            next_brake = 1'b1;
          end
        end
        ST_OFF_WAIT: begin
          if (off_wait_done) begin
            next_state = ST_IDLE;
            next_excite = 1'b0;
          end
        end
        ST_IDLE: begin
        end
        ST_RUN: begin
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
      if (pending && (brake_speed_met || brake_time_met)) begin
        next_brake = 1'b1;
        next_pending = 1'b0;
      end
    end
  end

  // Sequencer registers
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state <= ST_IDLE;
      HOLDING_BRAKE_OUTPUT <= 1'b0;
      MOTOR_EXCITE <= 1'b0;
      pending <= 1'b0;
    end else if (CE) begin
      state <= next_state;
      HOLDING_BRAKE_OUTPUT <= next_brake;
      MOTOR_EXCITE <= next_excite;
      pending <= next_pending;
    end
  end
endmodule

/* hw/servo_brake_pkg.sv */
package servo_brake_pkg;

  // Clock and millisecond tick timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_PERIOD_MS = 1;
  localparam int NS_PER_MS = 1000000;
  localparam int TICK_CYCLES = TICK_PERIOD_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int WAIT_UNIT_MS = 10;

  // Field widths
  localparam int ROT_W = 12;
  localparam int OVF_W = 27;
  localparam int SON_W = 12;
  localparam int SOFF_W = 9;
  localparam int BSPD_W = 7;
  localparam int BWAIT_W = 7;
  localparam int ELAPSED_W = 16;
  localparam int SPEED_W = 16;
  localparam int DEV_W = 32;

  // Setting limits
  localparam int ROT_MAX = 3000;
  localparam int OVF_MIN = 1;
  localparam int OVF_MAX = 83886080;
  localparam int SON_LIM = 2000;
  localparam int SOFF_MAX = 500;
  localparam int BSPD_MIN = 10;
  localparam int BSPD_MAX = 100;
  localparam int BWAIT_MIN = 10;
  localparam int BWAIT_MAX = 100;

  // Reset values
  localparam logic [ROT_W-1:0] ROT_RST = 12'h014;
  localparam logic [OVF_W-1:0] OVF_RST = 27'h000_0001;
  localparam logic [SON_W-1:0] SON_RST = 12'h000;
  localparam logic [SOFF_W-1:0] SOFF_RST = 9'h000;
  localparam logic [BSPD_W-1:0] BSPD_RST = 7'h64;
  localparam logic [BWAIT_W-1:0] BWAIT_RST = 7'h32;
  localparam logic CTRL_RST = 1'b0;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ROT = 8'h04;
  localparam logic [7:0] OFS_OVF = 8'h08;
  localparam logic [7:0] OFS_SON = 8'h0C;
  localparam logic [7:0] OFS_SOFF = 8'h10;
  localparam logic [7:0] OFS_BSPD = 8'h14;
  localparam logic [7:0] OFS_BWAIT = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  localparam logic [7:0] OFS_ELAPSED = 8'h20;

  // Field positions
  localparam int CTRL_BRAKE_EN_BIT = 0;
  localparam int STAT_ROT_BIT = 0;
  localparam int STAT_ALARM_BIT = 1;
  localparam int STAT_BRAKE_BIT = 2;
  localparam int STAT_EXCITE_BIT = 3;
  localparam int STAT_STATE_LSB = 4;

  // Bus constants
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  // Brake sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ON_WAIT,
    ST_RUN,
    ST_OFF_WAIT
  } seq_state_e;

endpackage

/* hw/ms_prescaler.sv */
`timescale 1ns/1ps
module ms_prescaler #(
  parameter int CYCLES = 250000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic restart,
  output logic tick
);
  localparam int CW = $clog2(CYCLES);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] count;

  // Cycle divider, phase reset on each new command
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count <= '0;
      tick <= 1'b0;
    end else if (ce) begin
      if (restart) begin
        count <= '0;
        tick <= 1'b0;
      end else if (count == LAST) begin
        count <= '0;
        tick <= 1'b1;
      end else begin
        count <= count + 1'b1;
        tick <= 1'b0;
      end
    end
  end
endmodule

/* hw/delay_timer.sv */
`timescale 1ns/1ps
module delay_timer #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic restart,
  input wire logic tick,
  output logic [W-1:0] elapsed
);
  wire at_max = &elapsed;

  // Millisecond count, saturating so long waits never wrap
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      elapsed <= '0;
    end else if (ce) begin
      if (restart) begin
        elapsed <= '0;
      end else if (tick && !at_max) begin
        elapsed <= elapsed + 1'b1;
      end
    end
  end
endmodule

/* verification/servo_brake_asserts.sv */
`timescale 1ns/1ps
module sbss_checker (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic HSEL,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic SERVO_ON_CMD,
  input wire logic [15:0] MOTOR_SPEED,
  input wire logic [31:0] DEVIATION_COUNT,
  input wire logic ROTATION_DETECTED,
  input wire logic DEVIATION_ALARM,
  input wire logic HOLDING_BRAKE_OUTPUT,
  input wire logic MOTOR_EXCITE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // Bus answers at once and never errs
  a_bus_okay: assert property (HREADYOUT && !HRESP)
    else $error("bus not ready or error response");
  a_rd_idle: assert property (CE && !(HSEL && HTRANS[1] && !HWRITE)
    |=> HRDATA == 32'h0000_0000) else $error("read data without read");
  // Rotation and deviation status
  a_rot_zero: assert property (CE && MOTOR_SPEED == 16'h0000
    |=> !ROTATION_DETECTED) else $error("rotation flag at standstill");
  a_rot_fast: assert property (CE && $signed(MOTOR_SPEED) > 3000
    |=> ROTATION_DETECTED) else $error("rotation flag missing");
  a_ovf_big: assert property (CE && $signed(DEVIATION_COUNT) > 83886080
    |=> DEVIATION_ALARM) else $error("overflow alarm missing");
  a_ovf_cause: assert property ($rose(DEVIATION_ALARM)
    |-> $past(DEVIATION_COUNT) != 0) else $error("alarm without deviation");
  // Brake and excitation ordering at servo commands
  a_on_answer: assert property ($rose(SERVO_ON_CMD) && CE
    |=> MOTOR_EXCITE || HOLDING_BRAKE_OUTPUT) else $error("no answer at on");
  a_off_stopped: assert property ($fell(SERVO_ON_CMD) && CE
    && !ROTATION_DETECTED |=> !HOLDING_BRAKE_OUTPUT) else $error("brake kept");
  a_pos_order: assert property ($rose(SERVO_ON_CMD) && CE ##1
    HOLDING_BRAKE_OUTPUT && !MOTOR_EXCITE |=> !MOTOR_EXCITE [*2])
    else $error("excite too early");
  a_neg_order: assert property ($rose(SERVO_ON_CMD) && CE ##1
    MOTOR_EXCITE && !HOLDING_BRAKE_OUTPUT |=> !HOLDING_BRAKE_OUTPUT [*2])
    else $error("brake too early");
endmodule
bind servo_brake_status_sequencer sbss_checker u_sbss_checker (.*);

/* verification/motor_plant.sv */
`timescale 1ns/1ps
module motor_plant (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic excite,
  input wire logic [15:0] target,
  input wire logic [31:0] dev_in,
  output logic [15:0] speed,
  output logic [31:0] dev
);
  // Powered motor follows target, unpowered motor coasts towards zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      speed <= 16'h0000;
    end else if (excite) begin
      speed <= target;
    end else if (speed != 16'h0000) begin
      speed <= $signed(speed) < 0 ? speed + 16'h0001 : speed - 16'h0001;
    end
  end
  // Deviation counter as the host leaves it
  assign dev = dev_in;
endmodule

/* verification/test_servo_brake_status_sequencer.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module test_servo_brake_status_sequencer;
  import servo_brake_pkg::*;
  localparam int TK = 4;
  logic CLK = 1'b0, RST_N = 1'b0, HSEL = 1'b0, HWRITE = 1'b0;
  logic SERVO_ON_CMD = 1'b0, HREADYOUT, HRESP, ROTATION_DETECTED;
  logic DEVIATION_ALARM, HOLDING_BRAKE_OUTPUT, MOTOR_EXCITE;
  logic CE = 1'b1;
  logic [31:0] HADDR = '0, HWDATA = '0, HRDATA, dev_in = '0, DEVIATION_COUNT;
  logic [1:0] HTRANS = '0;
  logic [2:0] HSIZE = '0;
  logic [15:0] MOTOR_SPEED, target = '0;
  int failures = 0, checked = 0, cycles = 0, n, m;
  // Clock and hang guard
  always #2 CLK = ~CLK;
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      stop_test;
    end
  end
  servo_brake_status_sequencer #(.TICK_CYCLES(TK))
    u_servo_brake_status_sequencer (.CLK(CLK), .RST_N(RST_N), .CE(CE),
    .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SERVO_ON_CMD(SERVO_ON_CMD),
    .MOTOR_SPEED(MOTOR_SPEED), .DEVIATION_COUNT(DEVIATION_COUNT),
    .ROTATION_DETECTED(ROTATION_DETECTED), .DEVIATION_ALARM(DEVIATION_ALARM),
    .HOLDING_BRAKE_OUTPUT(HOLDING_BRAKE_OUTPUT), .MOTOR_EXCITE(MOTOR_EXCITE));
  motor_plant u_motor_plant (.clk(CLK), .rst_n(RST_N), .excite(MOTOR_EXCITE),
    .target(target), .dev_in(dev_in), .speed(MOTOR_SPEED),
    .dev(DEVIATION_COUNT));
  // Single word transfer, held until ready is sampled high
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HSIZE <= HSIZE_WORD;
    HADDR <= {24'h00_0000, a};
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    q = HRDATA;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    `CHK("read", e, q)
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge CLK);
  endtask
  task automatic cmd(input logic v);
    @(posedge CLK);
    SERVO_ON_CMD <= v;
    cyc(2);
  endtask
  task automatic spd(input logic [15:0] s);
    @(posedge CLK);
    target <= s;
    cyc(3);
  endtask
  // Edges until brake (b=1) or excite reaches level v
  task automatic wt(input logic b, input logic v, output int k);
    for (k = 0; k < 1000; k++) begin
      @(posedge CLK);
      if ((b ? HOLDING_BRAKE_OUTPUT : MOTOR_EXCITE) === v) break;
    end
  endtask
  task automatic t_defaults;
    rd(OFS_CTRL, 32'h0000_0000);
    rd(OFS_ROT, 32'h0000_0014);
    rd(OFS_OVF, 32'h0000_0001);
    rd(OFS_SON, 32'h0000_0000);
    rd(OFS_SOFF, 32'h0000_0000);
    rd(OFS_BSPD, 32'h0000_0064);
    rd(OFS_BWAIT, 32'h0000_0032);
    rd(8'h40, 32'h0000_0000);
  endtask
  task automatic t_nobrake_rot;
    wr(OFS_SON, 32'h0000_0005);
    // Command edge held off while the clock enable is low
    CE <= 1'b0;
    cmd(1'b1);
    `CHK("frozen", 1'b0, MOTOR_EXCITE)
    CE <= 1'b1;
    cyc(2);
    `CHK("excite", 1'b1, MOTOR_EXCITE)
    `CHK("brake", 1'b0, HOLDING_BRAKE_OUTPUT)
    wr(OFS_ROT, 32'h0000_0FA0);
    rd(OFS_ROT, 32'h0000_0BB8);
    spd(16'h0BB8);
    `CHK("rot", 1'b0, ROTATION_DETECTED)
    spd(16'h0BB9);
    `CHK("rot", 1'b1, ROTATION_DETECTED)
    spd(16'hF447);
    `CHK("rot", 1'b1, ROTATION_DETECTED)
    spd(16'h0000);
    cmd(1'b0);
    `CHK("excite", 1'b0, MOTOR_EXCITE)
  endtask
  task automatic t_alarm;
    wr(OFS_OVF, 32'h0000_0064);
    dev_in <= 32'h0000_0064;
    cyc(3);
    `CHK("alarm", 1'b0, DEVIATION_ALARM)
    dev_in <= 32'hFFFF_FF9B;
    cyc(3);
    `CHK("alarm", 1'b1, DEVIATION_ALARM)
    dev_in <= 32'h0500_0001;
    rd(OFS_STATUS, 32'h0000_0002);
    // Clear in the same cycle as a live overflow: the overflow wins
    wr(OFS_STATUS, 32'h0000_0002);
    cyc(1);
    `CHK("set wins", 1'b1, DEVIATION_ALARM)
    dev_in <= 32'h0000_0000;
    wr(OFS_STATUS, 32'h0000_0002);
    cyc(2);
    `CHK("alarm", 1'b0, DEVIATION_ALARM)
  endtask
  task automatic t_on_order;
    wr(OFS_CTRL, 32'h0000_0001);
    wr(OFS_SON, 32'h0000_0003);
    cmd(1'b1);
    `CHK("brake", 1'b1, HOLDING_BRAKE_OUTPUT)
    wt(1'b0, 1'b1, n);
    `CHK("on wait", 1'b1, n >= 3 * TK - 2 && n <= 3 * TK + 4)
    cmd(1'b0);
    `CHK("brake", 1'b0, HOLDING_BRAKE_OUTPUT)
    wr(OFS_SON, 32'hFFFF_FFFD);
    rd(OFS_SON, 32'hFFFF_FFFD);
    cmd(1'b1);
    `CHK("excite", 1'b1, MOTOR_EXCITE)
    wt(1'b1, 1'b1, n);
    `CHK("neg wait", 1'b1, n >= 3 * TK - 2 && n <= 3 * TK + 4)
    cmd(1'b0);
  endtask
  // Servo off while moving: time path, then speed path
  task automatic t_off_moving;
    wr(OFS_ROT, 32'h0000_0014);
    wr(OFS_SON, 32'hFFFF_FF38);
    wr(OFS_SOFF, 32'h0000_0002);
    wr(OFS_BSPD, 32'h0000_0032);
    wr(OFS_BWAIT, 32'h0000_000A);
    for (int p = 0; p < 2; p++) begin
      spd(16'h03E8);
      cmd(1'b1);
      cyc(5);
      cmd(1'b0);
      `CHK("held", 1'b0, HOLDING_BRAKE_OUTPUT)
      if (p == 0) begin
        wt(1'b0, 1'b0, n);
        `CHK("off wait", 1'b1, n >= 20 * TK - 4 && n <= 20 * TK + 4)
        wt(1'b1, 1'b1, m);
        `CHK("brake t", 1'b1, n + m >= 398 && n + m <= 410)
      end else begin
        spd(16'h001E);
        wt(1'b1, 1'b1, n);
        `CHK("brake s", 1'b1, n <= 2)
      end
    end
  endtask
  task automatic stop_test;
    $display("failures=%0d checked=%0d", failures, checked);
    if (failures == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    cyc(2);
    RST_N <= 1'b1;
    t_defaults;
    t_nobrake_rot;
    t_alarm;
    t_on_order;
    t_off_moving;
    stop_test;
  end
endmodule
